// file: tb_top.sv
`timescale 1ns/1ps
`include "wmc_consts.svh"
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module tb_top;
  import wmc_pkg::*;
  localparam logic [31:0] OK_LINE = {`WMC_CH_O, `WMC_CH_K, `WMC_CH_CR, `WMC_CH_LF};
  localparam logic [31:0] ER_LINE = {`WMC_CH_E, `WMC_CH_R, `WMC_CH_CR, `WMC_CH_LF};
  localparam logic [39:0] ESC = 40'h2B2B2B0D0A;
  logic i_ref_clk, i_arst_n, i_cmd_valid, i_rx_valid, o_rx_ready, i_cfg_pin_n, i_lowpower_sel;
  logic i_link_up, i_peer_found, i_image_done, o_air_valid, i_air_ready, o_tx_valid, i_tx_ready, slow;
  logic [7:0] i_rx_data, o_air_data, o_tx_data, o_bond_used, aq[$];
  logic [47:0] i_peer_addr;
  wmc_cmd_t i_cmd;
  wmc_radio_t o_radio;
  wmc_mode_t o_mode;
  int err_count, tests_run, conns;
  wmc_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready), .i_cfg_pin_n(i_cfg_pin_n),
    .i_lowpower_sel(i_lowpower_sel), .i_link_up(i_link_up), .i_peer_found(i_peer_found),
    .i_peer_addr(i_peer_addr), .i_image_done(i_image_done), .o_air_valid(o_air_valid),
    .o_air_data(o_air_data), .i_air_ready(i_air_ready), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
    .i_tx_ready(i_tx_ready), .o_radio(o_radio), .o_mode(o_mode), .o_bond_used(o_bond_used));
  wmc_host_model i_host (.i_ref_clk(i_ref_clk), .i_slow(slow), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready), .o_lowpower_sel(i_lowpower_sel));
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) if (o_air_valid && i_air_ready) aq.push_back(o_air_data);
  always @(posedge i_ref_clk) if (o_radio.connect) conns++;
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic cmd(input wmc_op_t op, input logic a, input logic [47:0] ad, input logic [11:0] n);
    @(negedge i_ref_clk);
    i_cmd = '0;
    i_cmd.op = op;
    i_cmd.has_args = a;
    i_cmd.addr = ad;
    i_cmd.link = 3'h1;
    i_cmd.count = n;
    i_cmd_valid = 1'b1;
    @(negedge i_ref_clk);
    i_cmd_valid = 1'b0;
  endtask
  // the next command waits for the whole line, a reply cut short is lost
  task automatic reply(input logic [31:0] e);
    int k;
    k = 0;
    while (i_host.q.size() < 4 && k < 100) begin
      @(negedge i_ref_clk);
      k++;
    end
    chk({i_host.q[0], i_host.q[1], i_host.q[2], i_host.q[3]}, e);
    i_host.q.delete();
  endtask
  task automatic rx(input logic [39:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge i_ref_clk);
      i_rx_valid = 1'b1;
      i_rx_data = v[8*i +: 8];
      @(posedge i_ref_clk);
      while (o_rx_ready !== 1'b1) @(posedge i_ref_clk);
    end
    @(negedge i_ref_clk);
    i_rx_valid = 1'b0;
  endtask
  task automatic t_bond;
    slow = 1'b1;
    cmd(WMC_OP_SET_ADDR, 1'b1, 48'hA1, 12'h0);
    reply(OK_LINE);
    cmd(WMC_OP_CONNECT, 1'b1, 48'hB2, 12'h0);
    reply(OK_LINE);
    cmd(WMC_OP_CONNECT, 1'b1, 48'hC3, 12'h0);
    reply(OK_LINE);
    cmd(WMC_OP_DELETE_PAIRING, 1'b1, 48'hB2, 12'h0);
    reply(OK_LINE);
    chk(o_bond_used, 8'h02);
    cmd(WMC_OP_CONNECT, 1'b1, 48'hA1, 12'h0);
    reply(ER_LINE);
    chk(o_bond_used, 8'h02);
    chk(conns, 2);
    cmd(WMC_OP_DELETE_PAIRING, 1'b0, 48'h0, 12'h0);
    reply(OK_LINE);
    chk(o_bond_used, 8'h00);
    slow = 1'b0;
  endtask
  task automatic t_oneway;
    cmd(WMC_OP_ONEWAY, 1'b1, 48'h0, 12'h003);
    reply(OK_LINE);
    chk(o_mode, WMC_ONEWAY);
    aq.delete();
    rx(40'h414243, 3);
    chk(o_mode, WMC_CONFIG);
    repeat (4) @(negedge i_ref_clk);
    chk({aq.size(), aq[0], aq[1], aq[2]}, {32'h3, 24'h414243});
    cmd(WMC_OP_ONEWAY, 1'b1, 48'h0, 12'h800);
    reply(OK_LINE);
    rx(ESC, 5);
    chk(o_mode, WMC_CONFIG);
    cmd(WMC_OP_ONEWAY, 1'b1, 48'h0, 12'h801);
    reply(ER_LINE);
    chk(o_mode, WMC_CONFIG);
  endtask
  task automatic t_transp;
    int n;
    cmd(WMC_OP_LEAVE_CONFIG, 1'b0, 48'h0, 12'h0);
    reply(OK_LINE);
    chk({o_mode, o_radio.auto_link}, {WMC_TRANSP, 1'b1});
    aq.delete();
    i_air_ready = 1'b0;
    n = 0;
    repeat (12) begin
      @(negedge i_ref_clk);
      i_rx_valid = 1'b1;
      i_rx_data = 8'h41 + n[7:0];
      @(posedge i_ref_clk);
      if (o_rx_ready) n++;
    end
    @(negedge i_ref_clk);
    i_rx_valid = 1'b0;
    i_air_ready = 1'b1;
    repeat (12) @(negedge i_ref_clk);
    chk({n, aq.size()}, {32'h8, 32'h8});
    // the escape only counts at the start of a packet, so close the data packet first
    rx(40'h0A, 1);
    rx(ESC, 5);
    chk(o_mode, WMC_CONFIG);
    cmd(WMC_OP_LEAVE_CONFIG, 1'b0, 48'h0, 12'h0);
    reply(OK_LINE);
    i_cfg_pin_n = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    chk(o_mode, WMC_CONFIG);
    i_cfg_pin_n = 1'b1;
  endtask
  task automatic t_scan;
    cmd(WMC_OP_ADVERTISE, 1'b0, 48'h0, 12'h0);
    reply(OK_LINE);
    chk(o_radio.advertise, 1'b1);
    cmd(WMC_OP_DISCOVER, 1'b0, 48'h0, 12'h0);
    reply(OK_LINE);
    chk(o_radio.scan, 1'b1);
    @(negedge i_ref_clk);
    i_peer_found = 1'b1;
    i_peer_addr = 48'h5C;
    @(negedge i_ref_clk);
    i_peer_found = 1'b0;
    reply({`WMC_CH_PLUS, 8'h5C, `WMC_CH_CR, `WMC_CH_LF});
  endtask
  task automatic t_upgrade;
    cmd(WMC_OP_IDLE, 1'b0, 48'h0, 12'h0);
    reply(OK_LINE);
    chk({o_mode, o_radio.drop_all}, {WMC_IDLE, 1'b1});
    cmd(WMC_OP_UPGRADE, 1'b0, 48'h0, 12'h0);
    reply(ER_LINE);
    i_link_up = 1'b0;
    cmd(WMC_OP_UPGRADE, 1'b0, 48'h0, 12'h0);
    reply(OK_LINE);
    chk({o_mode, o_radio.advertise}, {WMC_UPGRADE, 1'b1});
    @(negedge i_ref_clk);
    i_image_done = 1'b1;
    @(negedge i_ref_clk);
    i_image_done = 1'b0;
    chk(o_radio.restart, 1'b1);
    @(negedge i_ref_clk);
    chk(o_mode, WMC_CONFIG);
    i_link_up = 1'b1;
  endtask
  task tally_and_finish;
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {i_arst_n, i_cmd_valid, i_rx_valid, i_peer_found, i_image_done, slow} = '0;
    {i_cfg_pin_n, i_air_ready, i_link_up} = 3'h7;
    i_rx_data = 8'h0;
    i_peer_addr = 48'h0;
    i_cmd = '0;
    repeat (16) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    chk({o_mode, o_bond_used, o_radio.advertise, o_radio.scan}, {WMC_CONFIG, 8'h00, 2'h0});
    t_bond();
    t_oneway();
    t_transp();
    t_scan();
    t_upgrade();
    tally_and_finish();
  end
  // whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_count++;
    $display("[ERR] %0t timeout", $time);
    tally_and_finish();
  end
endmodule // tb_top

// file: wmc_consts.svh
`ifndef WMC_CONSTS_SVH
`define WMC_CONSTS_SVH
// ----------------------------------------------------------------
// character codes
// ----------------------------------------------------------------
`define WMC_CH_CR 8'h0D
`define WMC_CH_LF 8'h0A
`define WMC_CH_PLUS 8'h2B
`define WMC_CH_O 8'h4F
`define WMC_CH_K 8'h4B
`define WMC_CH_E 8'h45
`define WMC_CH_R 8'h52
// ----------------------------------------------------------------
// sizes and limits
// ----------------------------------------------------------------
`define WMC_LINE_MAX 5'h10
`define WMC_SEND_MAX 12'h800
`define WMC_BOND_SLOTS 8
`define WMC_FIFO_DEPTH 8
`define WMC_ADDR_DIGITS 5'h0C
`endif

// file: wmc_ctrl.sv
`include "wmc_consts.svh"
`timescale 1ns/1ps
module wmc_ctrl
  import wmc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // decoded command, one-cycle strobe at the line terminator
  input wire logic i_cmd_valid,
  input wire wmc_cmd_t i_cmd,
  // raw serial bytes from the host
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  output logic o_rx_ready,
  // config-entry pin, low requests configuration in transparent mode only
  input wire logic i_cfg_pin_n,
  input wire logic i_lowpower_sel,
  // radio status
  input wire logic i_link_up,
  input wire logic i_peer_found,
  input wire logic [47:0] i_peer_addr,
  input wire logic i_image_done,
  // bytes forwarded to the radio
  output logic o_air_valid,
  output logic [7:0] o_air_data,
  input wire logic i_air_ready,
  // response bytes to the host
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  output wmc_radio_t o_radio,
  output wmc_mode_t o_mode,
  output logic [`WMC_BOND_SLOTS-1:0] o_bond_used
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wmc_mode_t mode;
  logic [47:0] own_addr;
  logic [47:0] bond_addr [`WMC_BOND_SLOTS];
  logic [`WMC_BOND_SLOTS-1:0] bond_type;
  logic [`WMC_BOND_SLOTS-1:0] bond_used;
  logic [`WMC_BOND_SLOTS-1:0] first_free;
  logic [11:0] send_left;
  logic advertising;
  logic scanning;
  logic [2:0] esc_pos;
  logic esc_hit;
  logic [2:0] tx_sel;
  logic [2:0] tx_len;
  logic [7:0] rx_hold [5];
  logic data_mode;
  logic fwd;
  logic fifo_in_ready;
  logic fifo_flush;
  logic cmd_ok;
  logic cmd_err;
  logic [47:0] peer_addr;
  logic peer_report;

  function automatic logic [7:0] esc_char(input logic [2:0] pos);
    unique case (pos)
      3'h0, 3'h1, 3'h2: esc_char = `WMC_CH_PLUS;
      3'h3: esc_char = `WMC_CH_CR;
      default: esc_char = `WMC_CH_LF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // escape line detector
  // ----------------------------------------------------------------
  // the escape must be a whole packet, so any mismatch blocks it until a line end;
  // a stray line end reopens the match for the next packet
  assign data_mode = (mode == WMC_TRANSP) || (mode == WMC_ONEWAY);
  assign esc_hit = i_rx_valid && o_rx_ready && data_mode && (esc_pos == 3'h4) &&
    (i_rx_data == `WMC_CH_LF);

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      esc_pos <= '0;
    end else if (!data_mode || esc_hit) begin
      esc_pos <= '0;
    end else if (i_rx_valid && o_rx_ready) begin
      if (i_rx_data == esc_char(esc_pos)) begin
        esc_pos <= esc_pos + 3'h1;
      end else begin
        esc_pos <= (i_rx_data == `WMC_CH_LF) ? 3'h0 : 3'h7;
      end
    end
  end

  // ----------------------------------------------------------------
  // data path into the radio
  // ----------------------------------------------------------------
  // bytes pass through a small buffer; back-pressure reaches the host
  assign o_rx_ready = data_mode ? fifo_in_ready : 1'b1;
  assign fwd = i_rx_valid && fifo_in_ready && data_mode && i_link_up;
  assign fifo_flush = !data_mode;

  wmc_fifo #(.WIDTH(8), .DEPTH(`WMC_FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_flush(fifo_flush),
    .i_valid(fwd),
    .o_ready(fifo_in_ready),
    .i_data(i_rx_data),
    .o_valid(o_air_valid),
    .i_ready(i_air_ready),
    .o_data(o_air_data)
  );

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode <= WMC_CONFIG;
      send_left <= '0;
    end else begin
      unique case (mode)
        WMC_CONFIG, WMC_IDLE: begin
          if (i_cmd_valid) begin
            unique case (i_cmd.op)
              WMC_OP_LEAVE_CONFIG: mode <= WMC_TRANSP;
              WMC_OP_IDLE: mode <= WMC_IDLE;
              WMC_OP_UPGRADE: begin
                if (mode == WMC_IDLE && !i_link_up) begin
                  mode <= WMC_UPGRADE;
                end
              end
              WMC_OP_ONEWAY: begin
                if (i_cmd.count != 12'h0 && i_cmd.count <= `WMC_SEND_MAX) begin
                  mode <= WMC_ONEWAY;
                  send_left <= i_cmd.count;
                end
              end
              default: mode <= mode;
            endcase
          end
        end
        WMC_TRANSP: begin
          if (esc_hit || !i_cfg_pin_n) begin
            mode <= WMC_CONFIG;
          end
        end
        WMC_ONEWAY: begin
          if (esc_hit || !i_link_up) begin
            mode <= WMC_CONFIG;
          end else if (fwd) begin
            send_left <= send_left - 12'h1;
            if (send_left == 12'h1) begin
              mode <= WMC_CONFIG;
            end
          end
        end
        WMC_UPGRADE: begin
          if (i_image_done) begin
            mode <= WMC_RESTART;
          end
        end
        WMC_RESTART: mode <= WMC_CONFIG;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // advertising and scanning
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      advertising <= 1'b0;
      scanning <= 1'b0;
    end else if (mode != WMC_CONFIG) begin
      advertising <= 1'b0;
      scanning <= 1'b0;
    end else if (i_cmd_valid) begin
      if (i_cmd.op == WMC_OP_ADVERTISE) begin
        advertising <= 1'b1;
      end
      if (i_cmd.op == WMC_OP_DISCOVER) begin
        scanning <= 1'b1;
      end
      if (i_cmd.op == WMC_OP_LEAVE_CONFIG || i_cmd.op == WMC_OP_IDLE) begin
        advertising <= 1'b0;
        scanning <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      own_addr <= '0;
    end else if (i_cmd_valid && mode == WMC_CONFIG && i_cmd.op == WMC_OP_SET_ADDR) begin
      own_addr <= i_cmd.addr;
    end
  end

  always_comb begin
    o_radio = '0;
    o_radio.advertise = advertising || (mode == WMC_UPGRADE);
    o_radio.scan = scanning;
    o_radio.auto_link = (mode == WMC_TRANSP);
    o_radio.connect = i_cmd_valid && (mode == WMC_CONFIG) && (i_cmd.op == WMC_OP_CONNECT) &&
      (i_cmd.addr != own_addr);
    o_radio.connect_addr = i_cmd.addr;
    o_radio.drop_all = (mode == WMC_IDLE);
    o_radio.restart = (mode == WMC_RESTART);
  end

  // ----------------------------------------------------------------
  // pairing store
  // ----------------------------------------------------------------
  // lowest clear bit only, so one accepted connect with the link up claims exactly one slot; a full store claims none
  assign first_free = ~bond_used & (bond_used + `WMC_BOND_SLOTS'(1));

  genvar g;
  generate
    for (g = 0; g < `WMC_BOND_SLOTS; g++) begin : g_bond
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          bond_used[g] <= 1'b0;
          bond_addr[g] <= '0;
          bond_type[g] <= 1'b0;
        end else if (i_cmd_valid && mode == WMC_CONFIG && i_cmd.op == WMC_OP_DELETE_PAIRING) begin
          if (!i_cmd.has_args) begin
            bond_used[g] <= 1'b0;
          end else if (bond_addr[g] == i_cmd.addr && bond_type[g] == i_cmd.addr_type) begin
            bond_used[g] <= 1'b0;
          end
        end else if (i_link_up && mode == WMC_CONFIG && i_cmd_valid && i_cmd.op == WMC_OP_CONNECT &&
                     first_free[g] && i_cmd.addr != own_addr) begin
          bond_used[g] <= 1'b1;
          bond_addr[g] <= i_cmd.addr;
          bond_type[g] <= i_cmd.addr_type;
        end
      end
    end
  endgenerate
  assign o_bond_used = bond_used;

  // ----------------------------------------------------------------
  // response lines
  // ----------------------------------------------------------------
  // answers are "OK" or "ER", peers found during a scan are reported as "+" lines
  // carrying the low peer address byte; a report arriving while a reply plays out is dropped
  assign cmd_ok = i_cmd_valid && (mode == WMC_CONFIG || mode == WMC_IDLE) &&
    !(i_cmd.op == WMC_OP_CONNECT && i_cmd.addr == own_addr) &&
    !(i_cmd.op == WMC_OP_UPGRADE && (mode != WMC_IDLE || i_link_up)) &&
    !(i_cmd.op == WMC_OP_ONEWAY && (i_cmd.count == 12'h0 || i_cmd.count > `WMC_SEND_MAX));
  assign cmd_err = i_cmd_valid && (mode == WMC_CONFIG || mode == WMC_IDLE) && !cmd_ok;
  assign peer_report = scanning && i_peer_found;
  assign peer_addr = i_peer_addr;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_len <= '0;
      tx_sel <= '0;
      for (int i = 0; i < 5; i++) begin
        rx_hold[i] <= 8'h00;
      end
    end else if (tx_len == 3'h0) begin
      tx_sel <= '0;
      if (cmd_ok || cmd_err) begin
        rx_hold[0] <= cmd_ok ? `WMC_CH_O : `WMC_CH_E;
        rx_hold[1] <= cmd_ok ? `WMC_CH_K : `WMC_CH_R;
        rx_hold[2] <= `WMC_CH_CR;
        rx_hold[3] <= `WMC_CH_LF;
        tx_len <= 3'h4;
      end else if (peer_report) begin
        rx_hold[0] <= `WMC_CH_PLUS;
        rx_hold[1] <= peer_addr[7:0];
        rx_hold[2] <= `WMC_CH_CR;
        rx_hold[3] <= `WMC_CH_LF;
        tx_len <= 3'h4;
      end
    end else if (i_tx_ready) begin
      if (tx_sel == tx_len - 3'h1) begin
        tx_len <= '0;
        tx_sel <= '0;
      end else begin
        tx_sel <= tx_sel + 3'h1;
      end
    end
  end

  assign o_tx_valid = (tx_len != 3'h0);
  assign o_tx_data = rx_hold[tx_sel];
  assign o_mode = mode;
endmodule // wmc_ctrl

// file: wmc_ctrl_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// properties at the controller ports
// ------------------------------------------------------------
module wmc_ctrl_chk
  import wmc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_cmd_valid,
  input wire wmc_cmd_t i_cmd,
  input wire logic i_cfg_pin_n,
  input wire logic i_image_done,
  input wire logic o_tx_valid,
  input wire wmc_radio_t o_radio,
  input wire wmc_mode_t o_mode
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  logic acc;
  assign acc = i_cmd_valid && (o_mode == WMC_CONFIG);
  a_reset_config: assert property ($rose(i_arst_n) |-> o_mode == WMC_CONFIG)
    else $error("not in config after reset");
  a_config_quiet: assert property ($changed(o_mode) && o_mode == WMC_CONFIG |-> !o_radio.advertise && !o_radio.scan)
    else $error("config entered with radio busy");
  a_leave_transp: assert property (acc && i_cmd.op == WMC_OP_LEAVE_CONFIG |=> o_mode == WMC_TRANSP)
    else $error("leave config missed");
  a_auto_link: assert property ($past(o_mode) == WMC_TRANSP && o_mode == WMC_TRANSP |-> o_radio.auto_link)
    else $error("no auto link");
  a_reply_start: assert property (acc && !o_tx_valid |=> o_tx_valid)
    else $error("reply late");
  a_pin_exit: assert property (o_mode == WMC_TRANSP && !i_cfg_pin_n |=> o_mode == WMC_CONFIG)
    else $error("pin exit missed");
  a_idle_drop: assert property (acc && i_cmd.op == WMC_OP_IDLE |=> o_mode == WMC_IDLE ##1 o_radio.drop_all)
    else $error("idle without drop");
  a_upgrade_adv: assert property ($past(o_mode) == WMC_UPGRADE && o_mode == WMC_UPGRADE |-> o_radio.advertise)
    else $error("upgrade not advertising");
  a_image_restart: assert property (o_mode == WMC_UPGRADE && i_image_done |=>
    o_radio.restart ##1 (o_mode == WMC_CONFIG && !o_radio.restart))
    else $error("restart wrong");
endmodule // wmc_ctrl_chk

bind wmc_ctrl wmc_ctrl_chk i_chk (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd), .i_cfg_pin_n(i_cfg_pin_n), .i_image_done(i_image_done), .o_tx_valid(o_tx_valid),
  .o_radio(o_radio), .o_mode(o_mode));

// file: wmc_fifo.sv
`timescale 1ns/1ps
module wmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_flush,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;

  assign o_ready = (fill != (AW+1)'(DEPTH));
  assign o_valid = (fill != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rd_ptr];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else if (i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // wmc_fifo

// file: wmc_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side: takes reply bytes, holds low-power select low
// ------------------------------------------------------------
module wmc_host_model (
  input wire logic i_ref_clk,
  input wire logic i_slow,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_lowpower_sel
);
  logic [7:0] q[$];
  assign o_lowpower_sel = 1'b0;
  // a slow host stalls every other cycle so reply bytes must stand until taken
  initial o_tx_ready = 1'b1;
  always @(negedge i_ref_clk) o_tx_ready <= i_slow ? !o_tx_ready : 1'b1;
  always @(posedge i_ref_clk) if (i_tx_valid && o_tx_ready) q.push_back(i_tx_data);
endmodule // wmc_host_model

// file: wmc_pkg.sv
package wmc_pkg;
  typedef enum logic [5:0] {
    WMC_CONFIG = 6'h01,
    WMC_TRANSP = 6'h02,
    WMC_ONEWAY = 6'h04,
    WMC_IDLE = 6'h08,
    WMC_UPGRADE = 6'h10,
    WMC_RESTART = 6'h20
  } wmc_mode_t;

  typedef enum logic [3:0] {
    WMC_OP_NONE = 4'h0,
    WMC_OP_DELETE_PAIRING = 4'h1,
    WMC_OP_LEAVE_CONFIG = 4'h2,
    WMC_OP_ADVERTISE = 4'h3,
    WMC_OP_DISCOVER = 4'h4,
    WMC_OP_CONNECT = 4'h5,
    WMC_OP_ONEWAY = 4'h6,
    WMC_OP_SET_ADDR = 4'h7,
    WMC_OP_IDLE = 4'h8,
    WMC_OP_UPGRADE = 4'h9
  } wmc_op_t;

  // command already decoded by the front end text scanner
  typedef struct packed {
    wmc_op_t op;
    logic has_args;
    logic [47:0] addr;
    logic addr_type;
    logic [2:0] link;
    logic [11:0] count;
  } wmc_cmd_t;

  // radio side controls
  typedef struct packed {
    logic advertise;
    logic scan;
    logic auto_link;
    logic connect;
    logic [47:0] connect_addr;
    logic drop_all;
    logic restart;
  } wmc_radio_t;
endpackage
